// [common/iipac_consts.vh]
// constants for the isa interrupt pass and access control block
`ifndef IIPAC_CONSTS_VH
`define IIPAC_CONSTS_VH

// register selects (no offsets printed; local byte selects)
`define IIPAC_SEL_FWD_LOW 1'b0
`define IIPAC_SEL_FWD_HIGH 1'b1

// reset values
`define IIPAC_FWD_LOW_RST 8'h00
`define IIPAC_FWD_HIGH_RST 3'h0
`define IIPAC_MODE_RST 1'b0
`define IIPAC_SEEN_RST 1'b0
`define IIPAC_RDATA_RST 8'h00

// field positions in the second register
`define IIPAC_BIT_SEEN 7
`define IIPAC_BIT_MODE 4
`define IIPAC_FWD_HIGH_MSB 2

// irq line count of the 11-line forwarding vector
`define IIPAC_NUM_LINES 11

`endif

// [src/iipac_ctrl.v]
// isa interrupt forwarding, wide card mode and access status registers
`timescale 1ns/1ps
`include "iipac_consts.vh"

module iipac_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // register port from the lpc decoder (same clock)
  input wire reg_sel,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // lpc decode event (same clock)
  input wire bus_cycle_decoded,
  // isa interrupt pins: 15,14,12,11,10,9,7,6,5,4,3 as bits 10..0
  input wire [10:0] isa_irq_in,
  // serial irq global enable, accepted but never used for gating
  input wire serial_irq_global_enable,
  // outputs
  output reg [10:0] serirq_fwd,
  output reg wide_card_access_mode
);

  // ==========================================================
  // registers
  reg [7:0] isa_irq_forward_low_reg;
  reg [2:0] fwd_high_reg;
  reg bus_access_seen_reg;
  reg bus_access_seen_next;
  reg [10:0] sync1_reg;
  reg [10:0] sync2_reg;
  wire [10:0] fwd_en;
  wire rd_high;
  wire unused_gen;

  assign fwd_en = {fwd_high_reg, isa_irq_forward_low_reg};
  assign rd_high = reg_rd && (reg_sel == `IIPAC_SEL_FWD_HIGH);
  // global enable left unconnected so software can prepare handlers first
  assign unused_gen = serial_irq_global_enable;

  // ==========================================================
  // control writes
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      isa_irq_forward_low_reg <= `IIPAC_FWD_LOW_RST;
      fwd_high_reg <= `IIPAC_FWD_HIGH_RST;
      wide_card_access_mode <= `IIPAC_MODE_RST;
    end else if (reg_wr) begin
      if (reg_sel == `IIPAC_SEL_FWD_LOW) begin
        isa_irq_forward_low_reg <= reg_wdata;
      end else begin
        // seen and reserved bits dropped
        fwd_high_reg <= reg_wdata[`IIPAC_FWD_HIGH_MSB:0];
        wide_card_access_mode <= reg_wdata[`IIPAC_BIT_MODE];
      end
    end
  end

  // ==========================================================
  // access seen: set beats the read clear
  always @* begin
    bus_access_seen_next = bus_access_seen_reg;
    if (rd_high) begin
      bus_access_seen_next = 1'b0;
    end
    if (bus_cycle_decoded) begin
      bus_access_seen_next = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_access_seen_reg <= `IIPAC_SEEN_RST;
    end else begin
      bus_access_seen_reg <= bus_access_seen_next;
    end
  end

  // ==========================================================
  // read data, registered; old seen value returned
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `IIPAC_RDATA_RST;
    end else if (reg_rd) begin
      if (reg_sel == `IIPAC_SEL_FWD_LOW) begin
        reg_rdata <= isa_irq_forward_low_reg;
      end else begin
        reg_rdata <= {bus_access_seen_reg, 2'h0, wide_card_access_mode,
                      1'h0, fwd_high_reg};
      end
    end
  end

  // ==========================================================
  // interrupt pass-through; pins are asynchronous, two flops then gate
  genvar i;
  generate
    for (i = 0; i < `IIPAC_NUM_LINES; i = i + 1) begin : g_line
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          serirq_fwd[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= isa_irq_in[i];
          sync2_reg[i] <= sync1_reg[i];
          // active high, no further filtering
          serirq_fwd[i] <= sync2_reg[i] & fwd_en[i];
        end
      end
    end
  endgenerate

endmodule

// [tb/iipac_far.sv]
// far side: isa cards and the lpc decoder
`timescale 1ns/1ps
module iipac_far (input wire [10:0] want, input wire hit,
  output wire [10:0] isa_irq_in, output wire bus_cycle_decoded);
  assign isa_irq_in = want;
  assign bus_cycle_decoded = hit;
endmodule

// [tb/iipac_chk.sv]
// assertions on the block ports
`timescale 1ns/1ps
module iipac_chk (
  // ports of the block
  input wire ref_clk, arst_n, reg_sel, reg_wr, reg_rd, bus_cycle_decoded,
  input wire [7:0] reg_wdata, reg_rdata,
  input wire [10:0] isa_irq_in, serirq_fwd,
  input wire serial_irq_global_enable, wide_card_access_mode);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire rq = reg_rd && reg_sel && !bus_cycle_decoded;
  irq_pass_a: assert property (
    (serirq_fwd & ~$past(isa_irq_in, 3)) == 0) else $error("stray irq");
  seen_clear_a: assert property (
    rq ##1 !bus_cycle_decoded ##1 rq |=> !reg_rdata[7]) else $error("seen");
  mode_wr_a: assert property (reg_wr && reg_sel |=>
    wide_card_access_mode == $past(reg_wdata[4])) else $error("mode");
  mode_rst_a: assert property (
    $rose(arst_n) |-> !wide_card_access_mode) else $error("mode reset");
  seen_set_a: assert property (
    bus_cycle_decoded ##1 !reg_rd ##1 rq |=> reg_rdata[7])
    else $error("seen set");
  seen_wins_a: assert property (
    reg_rd && reg_sel && bus_cycle_decoded ##1 !reg_rd ##1 rq
    |=> reg_rdata[7]) else $error("seen wins");
  reserved_zero_a: assert property (reg_rd && reg_sel |=>
    reg_rdata[6:5] == 2'h0 && !reg_rdata[3]) else $error("reserved");
  cover property (rq ##2 rq);
  cover property (reg_wr && reg_sel);
  cover property (|serirq_fwd);
endmodule
bind iipac_ctrl iipac_chk iipac_chk_i (.*);

// [tb/test_isa_irq_pass_and_access_control.sv]
// bench for the isa irq control block
`timescale 1ns/1ps
module test_isa_irq_pass_and_access_control;
  logic ref_clk = 0, arst_n = 0, reg_sel = 0, reg_wr = 0, reg_rd = 0, hit = 0;
  logic serial_irq_global_enable = 0, wide_card_access_mode, bus_cycle_decoded;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [10:0] want = 0, isa_irq_in, serirq_fwd;
  int fails = 0, cmp_count = 0, cyc = 0;
  // select, byte written, byte read back
  logic [16:0] rows [3] = '{17'h0A5A5, 17'h1FF17, 17'h1E800};
  iipac_far iipac_far_i (.*);
  iipac_ctrl iipac_ctrl_i (.*);
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 999) begin
    chk(0, 1, "timeout");
    finish_test();
  end
  task chk(input logic [10:0] s, e, input string n);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task acc(input logic s, w, input logic [7:0] d);
    @(posedge ref_clk) {reg_sel, reg_wr, reg_rd, reg_wdata} <= {s, w, !w, d};
    @(posedge ref_clk) {reg_wr, reg_rd} <= 2'h0;
    #1;
  endtask
  task finish_test;
    $display("%0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1;
    foreach (rows[i]) begin
      acc(rows[i][16], 1, rows[i][15:8]);
      acc(rows[i][16], 0, 0);
      chk(reg_rdata, rows[i][7:0], "readback");
    end
    $display("rows done");
    acc(0, 1, 8'hFF);
    acc(1, 1, 8'h07);
    want <= 11'h5A5;
    #161 chk(serirq_fwd, 11'h5A5, "pass");
    serial_irq_global_enable <= 1;
    acc(0, 1, 8'h0F);
    #40 chk(serirq_fwd, 11'h5A5 & 11'h70F, "mask");
    hit <= 1;
    @(posedge ref_clk) hit <= 0;
    acc(1, 0, 0);
    chk(reg_rdata, 8'h87, "seen");
    acc(1, 0, 0);
    chk(reg_rdata, 8'h07, "cleared");
    $display("irq and status done");
    acc(1, 1, 8'h10);
    chk(wide_card_access_mode, 1, "mode out");
    arst_n <= 0;
    @(posedge ref_clk) arst_n <= 1;
    acc(1, 0, 0);
    chk(reg_rdata, 8'h00, "reset");
    chk(wide_card_access_mode, 0, "mode reset");
    chk(serirq_fwd, 11'h000, "reset pass");
    acc(0, 0, 0);
    chk(reg_rdata, 8'h00, "low reset");
    @(posedge ref_clk) {reg_sel, reg_rd, hit} <= 3'h7;
    @(posedge ref_clk) {reg_rd, hit} <= 2'h0;
    acc(1, 0, 0);
    chk(reg_rdata, 8'h80, "decode wins");
    $display("reset done");
    finish_test();
  end
endmodule
